// >>> hw/dtx_exec.sv
/*
 * data-transfer execution unit of an 8-bit core: moves, pair copy,
 * constant loads, pointer / offset / absolute loads, pointer stores
 * and the clear-half-carry instruction.
 * assumes a decoded instruction with a valid/ready handshake and a
 * data memory that answers a read with mem_rvalid one or more cycles
 * after the request.
 */
// Notes on behaviour
// - clear-half-carry zeroes status bit H, other status bits kept.
// - register move copies source into destination, no flag change.
// - pair copy moves source pair into destination pair at once.
// - constant load puts instruction constant in destination, flags kept.
// - plain pointer load reads byte at pointer, pointer unchanged.
// - post-increment load reads at pointer, then pointer plus one.
// - pre-decrement load subtracts one first, then reads there.
// - offset load reads second/third pointer plus displacement, pointer kept.
// - absolute load reads byte at the instruction's address constant.
// - pointer store writes source byte at pointer, no flag change.
// - store post-increment / pre-decrement update pointer like loads.
`timescale 1ns/1ps
`default_nettype none
module dtx_exec (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire dtx_pkg::dtx_op_t instr_op,
    input wire dtx_pkg::dtx_mode_t instr_mode,
    input wire dtx_pkg::dtx_ptr_t instr_ptr,
    input wire logic [4:0] instr_dst,
    input wire logic [4:0] src_reg,
    input wire logic [7:0] instr_const,
    input wire logic [5:0] instr_disp,
    input wire logic [15:0] instr_addr,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    output logic [7:0] status_register,
    output logic done
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [1:0] {
        DTX_ST_IDLE,
        DTX_ST_WAIT
    } dtx_state_t;

    dtx_state_t state_q, state_d;
    logic [4:0] dst_q;
    logic [7:0] status_q;
    logic done_q;

    dtx_rf_if rf ();

    dtx_regfile u_regs (
        .mclk(mclk),
        .rst_n(rst_n),
        .rf(rf)
    );

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic [4:0] ptr_lo(input dtx_pkg::dtx_ptr_t p);
        case (p)
            dtx_pkg::DTX_PTR_SECOND: ptr_lo = dtx_pkg::DTX_PTR_SECOND_LO;
            dtx_pkg::DTX_PTR_THIRD: ptr_lo = dtx_pkg::DTX_PTR_THIRD_LO;
            default: ptr_lo = dtx_pkg::DTX_PTR_FIRST_LO;
        endcase
    endfunction

    wire take = instr_valid && instr_ready;
    wire is_clh = instr_op == dtx_pkg::DTX_OP_CLEAR_HALF_CARRY;
    wire is_mov = instr_op == dtx_pkg::DTX_OP_REG_MOVE;
    wire is_copy = instr_op == dtx_pkg::DTX_OP_PAIR_COPY;
    wire is_ldi = instr_op == dtx_pkg::DTX_OP_LOAD_CONSTANT;
    wire is_ptr_ld = instr_op == dtx_pkg::DTX_OP_POINTER_LOAD;
    wire is_off_ld = instr_op == dtx_pkg::DTX_OP_OFFSET_LOAD;
    wire is_abs_ld = instr_op == dtx_pkg::DTX_OP_ABSOLUTE_LOAD;
    wire is_st = instr_op == dtx_pkg::DTX_OP_POINTER_STORE;
    wire is_load = is_ptr_ld || is_off_ld || is_abs_ld;
    wire uses_ptr = is_ptr_ld || is_st;
    wire post_inc = uses_ptr && instr_mode == dtx_pkg::DTX_MODE_POST_INC;
    wire pre_dec = uses_ptr && instr_mode == dtx_pkg::DTX_MODE_PRE_DEC;

    // offset loads use only the second or third pair
    wire dtx_pkg::dtx_ptr_t sel_ptr = (is_off_ld &&
        instr_ptr == dtx_pkg::DTX_PTR_FIRST) ? dtx_pkg::DTX_PTR_SECOND
        : instr_ptr;
    wire [4:0] sel_lo = ptr_lo(sel_ptr);
    wire [15:0] ptr_val = (sel_ptr == dtx_pkg::DTX_PTR_SECOND) ?
        rf.ptr_second : (sel_ptr == dtx_pkg::DTX_PTR_THIRD) ?
        rf.ptr_third : rf.ptr_first;
    // full 16-bit add so carry/borrow crosses the byte boundary
    wire [15:0] ptr_inc = ptr_val + dtx_pkg::DTX_ONE;
    wire [15:0] ptr_dec = ptr_val - dtx_pkg::DTX_ONE;
    wire [15:0] ptr_disp = ptr_val + {10'h000, instr_disp};

    // ----------------------------------------
    // memory address select
    // ----------------------------------------
    wire [15:0] addr_sel = is_abs_ld ? instr_addr
        : is_off_ld ? ptr_disp
        : pre_dec ? ptr_dec
        : ptr_val;

    assign instr_ready = state_q == DTX_ST_IDLE;
    assign mem_req = take && (is_load || is_st);
    assign mem_we = take && is_st;
    assign mem_addr = addr_sel;
    assign mem_wdata = rf.rb_data;

    // ----------------------------------------
    // register file ports
    // ----------------------------------------
    assign rf.ra_addr = src_reg;
    // pair copy takes the high source byte from port b
    assign rf.rb_addr = is_copy ? src_reg + 5'h01 : src_reg;
    // byte writes: move, constant, copy low byte on take, load on return
    wire load_ret = state_q == DTX_ST_WAIT && mem_rvalid;
    assign rf.wa_en = load_ret || (take && (is_mov || is_ldi || is_copy));
    assign rf.wa_addr = load_ret ? dst_q : instr_dst;
    assign rf.wa_data = load_ret ? mem_rdata
        : is_ldi ? instr_const
        : rf.ra_data;
    // pair copy: low byte on port a, high on port b, one edge
    assign rf.wb_en = take && is_copy;
    assign rf.wb_addr = instr_dst + 5'h01;
    assign rf.wb_data = rf.rb_data;
    // pointer update only; ready is low while a load waits, so the
    // returning byte never meets a pointer write in one cycle
    assign rf.wp_en = take && (post_inc || pre_dec);
    assign rf.wp_addr = sel_lo;
    assign rf.wp_data = post_inc ? ptr_inc
        : ptr_dec;

    // ----------------------------------------
    // state, status, done
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            DTX_ST_IDLE: if (take && is_load) state_d = DTX_ST_WAIT;
            DTX_ST_WAIT: if (mem_rvalid) state_d = DTX_ST_IDLE;
            default: state_d = DTX_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DTX_ST_IDLE;
            dst_q <= 5'h00;
            status_q <= dtx_pkg::DTX_STATUS_RESET;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (take) dst_q <= instr_dst;
            if (take && is_clh)
                status_q[dtx_pkg::DTX_HALF_CARRY_BIT] <= 1'b0;
            done_q <= load_ret || (take && !is_load);
        end
    end

    assign status_register = status_q;
    assign done = done_q;
endmodule
`default_nettype wire

// >>> hw/dtx_pkg.sv
/*
 * package for the data-transfer execution unit: operation codes,
 * register indices, flag positions, reset values.
 * assumes a 32 x 8 working register file and a 16-bit data space.
 */
package dtx_pkg;
    // ----------------------------------------
    // operations
    // ----------------------------------------
    typedef enum logic [3:0] {
        DTX_OP_CLEAR_HALF_CARRY,
        DTX_OP_REG_MOVE,
        DTX_OP_PAIR_COPY,
        DTX_OP_LOAD_CONSTANT,
        DTX_OP_POINTER_LOAD,
        DTX_OP_OFFSET_LOAD,
        DTX_OP_ABSOLUTE_LOAD,
        DTX_OP_POINTER_STORE
    } dtx_op_t;

    typedef enum logic [1:0] {
        DTX_MODE_PLAIN,
        DTX_MODE_POST_INC,
        DTX_MODE_PRE_DEC
    } dtx_mode_t;

    typedef enum logic [1:0] {
        DTX_PTR_FIRST,
        DTX_PTR_SECOND,
        DTX_PTR_THIRD
    } dtx_ptr_t;

    // ----------------------------------------
    // constants
    // ----------------------------------------
    localparam int DTX_REG_COUNT = 32;
    localparam logic [4:0] DTX_PTR_FIRST_LO = 5'h1A;
    localparam logic [4:0] DTX_PTR_SECOND_LO = 5'h1C;
    localparam logic [4:0] DTX_PTR_THIRD_LO = 5'h1E;
    localparam int DTX_HALF_CARRY_BIT = 5;
    localparam logic [7:0] DTX_STATUS_RESET = 8'h00;
    localparam logic [7:0] DTX_REG_RESET = 8'h00;
    localparam logic [15:0] DTX_ONE = 16'h0001;
endpackage

// >>> hw/dtx_rf_if.sv
/*
 * interface carrying the register-file ports between the executor
 * and its register file. assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface dtx_rf_if;
    logic [4:0] ra_addr;
    logic [4:0] rb_addr;
    logic [7:0] ra_data;
    logic [7:0] rb_data;
    logic [15:0] ptr_first;
    logic [15:0] ptr_second;
    logic [15:0] ptr_third;
    logic wa_en;
    logic [4:0] wa_addr;
    logic [7:0] wa_data;
    logic wb_en;
    logic [4:0] wb_addr;
    logic [7:0] wb_data;
    logic wp_en;
    logic [4:0] wp_addr;
    logic [15:0] wp_data;
    modport exec (
        output ra_addr, rb_addr, wa_en, wa_addr, wa_data,
        output wb_en, wb_addr, wb_data, wp_en, wp_addr, wp_data,
        input ra_data, rb_data, ptr_first, ptr_second, ptr_third
    );
    modport regs (
        input ra_addr, rb_addr, wa_en, wa_addr, wa_data,
        input wb_en, wb_addr, wb_data, wp_en, wp_addr, wp_data,
        output ra_data, rb_data, ptr_first, ptr_second, ptr_third
    );
endinterface
`default_nettype wire

// >>> hw/dtx_regfile.sv
/*
 * working register file: 32 bytes, two read ports, two byte write
 * ports and one 16-bit pair write port. assumes mclk and rst_n.
 */
`timescale 1ns/1ps
`default_nettype none
module dtx_regfile (
    input wire logic mclk,
    input wire logic rst_n,
    dtx_rf_if.regs rf
);
    logic [7:0] mem_q [dtx_pkg::DTX_REG_COUNT];

    assign rf.ra_data = mem_q[rf.ra_addr];
    assign rf.rb_data = mem_q[rf.rb_addr];
    // pointers are two adjacent registers, low byte first
    assign rf.ptr_first = {mem_q[dtx_pkg::DTX_PTR_FIRST_LO + 5'h01],
                           mem_q[dtx_pkg::DTX_PTR_FIRST_LO]};
    assign rf.ptr_second = {mem_q[dtx_pkg::DTX_PTR_SECOND_LO + 5'h01],
                            mem_q[dtx_pkg::DTX_PTR_SECOND_LO]};
    assign rf.ptr_third = {mem_q[dtx_pkg::DTX_PTR_THIRD_LO + 5'h01],
                           mem_q[dtx_pkg::DTX_PTR_THIRD_LO]};

    // ----------------------------------------
    // write ports; first port in the chain wins on a clash
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < dtx_pkg::DTX_REG_COUNT; i++) begin : g_reg
            localparam logic [4:0] IDX = 5'(i);
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[i] <= dtx_pkg::DTX_REG_RESET;
                end else if (rf.wa_en && rf.wa_addr == IDX) begin
                    mem_q[i] <= rf.wa_data;
                end else if (rf.wb_en && rf.wb_addr == IDX) begin
                    mem_q[i] <= rf.wb_data;
                end else if (rf.wp_en && rf.wp_addr == IDX) begin
                    mem_q[i] <= rf.wp_data[7:0];
                end else if (rf.wp_en && rf.wp_addr + 5'h01 == IDX) begin
                    mem_q[i] <= rf.wp_data[15:8];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> verif/dtx_exec_assertions.sv
/* checker for dtx_exec: handshake, memory requests, status flags.
   assumes a bind onto the dtx_exec ports, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module dtx_exec_assertions (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire dtx_pkg::dtx_op_t instr_op,
    input wire logic [15:0] instr_addr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rvalid,
    input wire logic [7:0] status_register,
    input wire logic done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [15:0] addr_q;
    wire take = instr_valid && instr_ready;
    wire is_clh = instr_op == dtx_pkg::DTX_OP_CLEAR_HALF_CARRY;
    wire is_abs = instr_op == dtx_pkg::DTX_OP_ABSOLUTE_LOAD;
    wire is_st = instr_op == dtx_pkg::DTX_OP_POINTER_STORE;
    wire is_ld = is_abs || instr_op == dtx_pkg::DTX_OP_POINTER_LOAD
        || instr_op == dtx_pkg::DTX_OP_OFFSET_LOAD;
    // address kept for a request issued one cycle after the take
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) addr_q <= 16'h0000;
        else if (take) addr_q <= instr_addr;
    end
    sequence s_take_ld;
        take && is_ld;
    endsequence
    sequence s_rd_req;
        mem_req && !mem_we;
    endsequence
    half_clear_a: assert property (take && is_clh |=>
        !status_register[dtx_pkg::DTX_HALF_CARRY_BIT])
        else $error("half carry not cleared");
    other_flags_a: assert property (take && is_clh |=>
        (status_register | 8'h20) == ($past(status_register) | 8'h20))
        else $error("other status bits changed");
    flags_kept_a: assert property (!(take && is_clh) |=>
        $stable(status_register)) else $error("status changed");
    done_op_a: assert property (take && !is_ld |=> done)
        else $error("done missing after operation");
    done_data_a: assert property (mem_rvalid |=> done)
        else $error("done missing after read data");
    done_cause_a: assert property (done |-> $past(take)
        || $past(mem_rvalid)) else $error("done without cause");
    load_req_a: assert property (s_take_ld |-> ##[0:1] s_rd_req)
        else $error("load issued no read");
    store_req_a: assert property (take && is_st |-> ##[0:1]
        (mem_req && mem_we)) else $error("store issued no write");
    abs_addr_a: assert property (take && is_abs |->
        (mem_req && mem_addr == instr_addr) or
        ##1 (mem_req && mem_addr == addr_q)) else $error("bad address");
    ready_wait_a: assert property (s_rd_req |=> !instr_ready)
        else $error("ready while load waits");
endmodule
bind dtx_exec dtx_exec_assertions u_dtx_chk (.mclk(mclk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_op(instr_op), .instr_addr(instr_addr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
    .status_register(status_register), .done(done));
`default_nettype wire

// >>> verif/dtx_mem_model.sv
/* data memory model: byte array, reads answered after lat cycles.
   assumes one single-cycle request at a time. */
`timescale 1ns/1ps
`default_nettype none
module dtx_mem_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_rvalid
);
    logic [7:0] data [65536];
    logic [15:0] rd_a;
    int lat = 1;
    int cnt;
    initial for (int i = 0; i < 65536; i++) data[i] = i[7:0] ^ i[15:8] ^ 8'hC3;
    // idle read data toggles so a stale byte never looks valid
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_rvalid <= 1'b0;
            mem_rdata <= 8'h00;
            cnt <= 0;
        end else begin
            mem_rvalid <= cnt == 1;
            mem_rdata <= (cnt == 1) ? data[rd_a] : ~mem_rdata;
            if (cnt != 0) cnt <= cnt - 1;
            if (mem_req && mem_we) data[mem_addr] <= mem_wdata;
            else if (mem_req && cnt == 0) begin
                rd_a <= mem_addr;
                cnt <= lat;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb.sv
/* testbench for dtx_exec: drives decoded instructions, reads results
   back through stores. assumes the memory model and the checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam dtx_pkg::dtx_mode_t MP = dtx_pkg::DTX_MODE_PLAIN;
    localparam dtx_pkg::dtx_mode_t MI = dtx_pkg::DTX_MODE_POST_INC;
    localparam dtx_pkg::dtx_mode_t MD = dtx_pkg::DTX_MODE_PRE_DEC;
    localparam dtx_pkg::dtx_ptr_t P1 = dtx_pkg::DTX_PTR_FIRST;
    localparam dtx_pkg::dtx_ptr_t P2 = dtx_pkg::DTX_PTR_SECOND;
    localparam dtx_pkg::dtx_ptr_t P3 = dtx_pkg::DTX_PTR_THIRD;
    localparam dtx_pkg::dtx_op_t O_K = dtx_pkg::DTX_OP_LOAD_CONSTANT;
    localparam dtx_pkg::dtx_op_t O_PL = dtx_pkg::DTX_OP_POINTER_LOAD;
    localparam dtx_pkg::dtx_op_t O_OL = dtx_pkg::DTX_OP_OFFSET_LOAD;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic instr_ready, mem_req, mem_we, mem_rvalid, done;
    dtx_pkg::dtx_op_t instr_op = O_K;
    dtx_pkg::dtx_mode_t instr_mode = MP;
    dtx_pkg::dtx_ptr_t instr_ptr = P1;
    logic [4:0] instr_dst = 5'h00;
    logic [4:0] src_reg = 5'h00;
    logic [7:0] instr_const = 8'h00;
    logic [5:0] instr_disp = 6'h00;
    logic [15:0] instr_addr = 16'h0000;
    logic [7:0] mem_wdata, mem_rdata, status_register;
    logic [15:0] mem_addr;
    int fails = 0;
    int num_checks = 0;
    dtx_exec dut (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .instr_op(instr_op),
        .instr_mode(instr_mode), .instr_ptr(instr_ptr),
        .instr_dst(instr_dst), .src_reg(src_reg),
        .instr_const(instr_const), .instr_disp(instr_disp),
        .instr_addr(instr_addr), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid), .status_register(status_register),
        .done(done));
    dtx_mem_model mem (.mclk(mclk), .rst_n(rst_n), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
    task automatic finish_test;
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input dtx_pkg::dtx_op_t o, input dtx_pkg::dtx_mode_t m,
            input dtx_pkg::dtx_ptr_t p, input logic [4:0] d,
            input logic [4:0] s, input logic [7:0] k,
            input logic [5:0] q, input logic [15:0] a);
        int n;
        instr_op = o;
        instr_mode = m;
        instr_ptr = p;
        instr_dst = d;
        src_reg = s;
        instr_const = k;
        instr_disp = q;
        instr_addr = a;
        instr_valid = 1'b1;
        n = 0;
        while (instr_ready !== 1'b1 && n < 50) begin
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk);
        #1;
        instr_valid = 1'b0;
        // done may already be up in the cycle right after the take
        while (done !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 100) begin
            fails++;
            finish_test();
        end
        @(posedge mclk);
        #1;
    endtask
    task automatic ldk(input logic [4:0] d, input logic [7:0] k);
        run(O_K, MP, P1, d, 5'h00, k, 6'h00, 16'h0000);
    endtask
    task automatic setp(input logic [4:0] lo, input logic [15:0] v);
        ldk(lo, v[7:0]);
        ldk(lo + 5'h01, v[15:8]);
    endtask
    task automatic st(input dtx_pkg::dtx_mode_t m, input dtx_pkg::dtx_ptr_t p,
            input logic [4:0] s);
        run(dtx_pkg::DTX_OP_POINTER_STORE, m, p, 5'h00, s, 8'h00, 6'h00,
            16'h0000);
    endtask
    task automatic t_status;
        chk(status_register, dtx_pkg::DTX_STATUS_RESET);
        run(dtx_pkg::DTX_OP_CLEAR_HALF_CARRY, MP, P1, 5'h00, 5'h00, 8'h00,
            6'h00, 16'h0000);
        chk(status_register, dtx_pkg::DTX_STATUS_RESET);
    endtask
    task automatic t_store;
        ldk(5'h01, 8'hA5);
        setp(dtx_pkg::DTX_PTR_FIRST_LO, 16'h12FF);
        st(MI, P1, 5'h01);
        chk(mem.data[16'h12FF], 8'hA5);
        ldk(5'h01, 8'h3C);
        st(MP, P1, 5'h01);
        chk(mem.data[16'h1300], 8'h3C);
        ldk(5'h01, 8'h77);
        st(MD, P1, 5'h01);
        chk(mem.data[16'h12FF], 8'h77);
    endtask
    task automatic t_move;
        ldk(5'h02, 8'h5A);
        run(dtx_pkg::DTX_OP_REG_MOVE, MP, P1, 5'h03, 5'h02, 8'h00, 6'h00,
            16'h0000);
        st(MP, P1, 5'h03);
        chk(mem.data[16'h12FF], 8'h5A);
    endtask
    task automatic t_pair;
        ldk(5'h04, 8'h11);
        ldk(5'h05, 8'h22);
        run(dtx_pkg::DTX_OP_PAIR_COPY, MP, P1, 5'h06, 5'h04, 8'h00, 6'h00,
            16'h0000);
        st(MI, P1, 5'h06);
        st(MP, P1, 5'h07);
        chk(mem.data[16'h12FF], 8'h11);
        chk(mem.data[16'h1300], 8'h22);
    endtask
    task automatic t_loads;
        logic [15:0] ea [7] = '{16'h20FF, 16'h2100, 16'h00FF, 16'h213F,
            16'h0210, 16'hBEEF, 16'h01F0};
        setp(dtx_pkg::DTX_PTR_SECOND_LO, 16'h20FF);
        setp(dtx_pkg::DTX_PTR_THIRD_LO, 16'h01F0);
        setp(dtx_pkg::DTX_PTR_FIRST_LO, 16'h0100);
        run(O_PL, MI, P2, 5'h08, 5'h00, 8'h00, 6'h00, 16'h0000);
        mem.lat = 4;
        run(O_PL, MP, P2, 5'h09, 5'h00, 8'h00, 6'h00, 16'h0000);
        run(O_PL, MD, P1, 5'h0A, 5'h00, 8'h00, 6'h00, 16'h0000);
        run(O_OL, MP, P2, 5'h0B, 5'h00, 8'h00, 6'h3F, 16'h0000);
        run(O_OL, MP, P3, 5'h0C, 5'h00, 8'h00, 6'h20, 16'h0000);
        run(dtx_pkg::DTX_OP_ABSOLUTE_LOAD, MP, P1, 5'h0D, 5'h00, 8'h00,
            6'h00, 16'hBEEF);
        run(O_PL, MP, P3, 5'h0E, 5'h00, 8'h00, 6'h00, 16'h0000);
        setp(dtx_pkg::DTX_PTR_FIRST_LO, 16'h3000);
        for (int i = 0; i < 7; i++) st(MI, P1, 5'h08 + 5'(i));
        for (int i = 0; i < 7; i++)
            chk(mem.data[16'h3000 + 16'(i)], ea[i][7:0] ^ ea[i][15:8] ^ 8'hC3);
    endtask
    initial forever #5 mclk = ~mclk;
    initial begin
        repeat (4) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_status();
        t_store();
        t_move();
        t_pair();
        t_loads();
        finish_test();
    end
endmodule
`default_nettype wire
